/* File: core/pmupi_pkg.sv */
// constants for the power management pin interface
`default_nettype none
package pmupi_pkg;
	localparam int GPIO_W = 4;
	localparam int PIO_W = 7;
	localparam int UIO_W = 3;
	localparam int IO_W = GPIO_W + PIO_W + UIO_W;
	// field positions inside the combined io vector
	localparam int GPIO_LSB = 0;
	localparam int PIO_LSB = GPIO_W;
	localparam int UIO_LSB = GPIO_W + PIO_W;
	// indicator vector field positions
	localparam int IND_W = 6;
	localparam int IND_AC = 0;
	localparam int IND_LB = 1;
	localparam int IND_VLB = 2;
	localparam int IND_THERM = 3;
	localparam int IND_RING = 4;
	localparam int IND_EXTS = 5;
	// reset levels of the pin outputs
	localparam logic DOZE_RST = 1'b1;
	localparam logic PWRDN_RST = 1'b0;
	localparam logic SUSP_N_RST = 1'b1;
	localparam logic STBY_N_RST = 1'b1;
	localparam logic IRQ_N_RST = 1'b1;
	localparam logic [IO_W-1:0] IO_DIR_RST = 14'h0000;
	localparam logic [IO_W-1:0] IO_DAT_RST = 14'h0000;
	// suspend tick counter
	localparam int SUSP_CNT_W = 16;
	localparam logic [SUSP_CNT_W-1:0] SUSP_CNT_RST = 16'h0000;
	localparam logic [SUSP_CNT_W-1:0] SUSP_CNT_MAX = 16'hffff;
	typedef enum logic [1:0] {
		PMUPI_IRQ_IDLE = 2'b00,
		PMUPI_IRQ_REQ = 2'b01,
		PMUPI_IRQ_REL = 2'b10
	} pmupi_irq_e;
endpackage : pmupi_pkg
`default_nettype wire

/* File: core/pmupi_top.sv */
// power management pin interface: outputs, indicators and io pins
// Behaviour
// - doze output is high at power-on and power-good, low when dozing
// - power-down request output low at reset, high only to request it
// - active-low suspend status low while system is in suspend mode
// - active-low standby status low while system is in standby mode
// - active-low management interrupt request, high at reset
// - four general and seven programmable io pins, all inputs after reset
// - three user io pins, each bit written alone, inputs after reset
// - thermal indicator is active high
// - ring indicator activation is a wake-up event
// - suspend timing comes from the 32 kHz oscillator input
`default_nettype none
module pmupi_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic doze_req_i,
	input wire logic power_down_cmd_i,
	input wire logic suspend_mode_i,
	input wire logic standby_mode_i,
	input wire logic mgmt_irq_set_i,
	input wire logic mgmt_irq_ack_n_i,
	input wire logic stop_grant_in_i,
	input wire logic suspend_clk_in_i,
	input wire logic ac_power_present_i,
	input wire logic battery_low_i,
	input wire logic battery_very_low_i,
	input wire logic thermal_alarm_i,
	input wire logic ring_wake_i,
	input wire logic external_suspend_req_i,
	input wire logic [13:0] io_dir_we_i,
	input wire logic [13:0] io_dir_i,
	input wire logic [13:0] io_dat_we_i,
	input wire logic [13:0] io_dat_i,
	input wire logic [3:0] gpio_in_i,
	input wire logic [6:0] prog_io_pins_in_i,
	input wire logic [2:0] user_io_pins_in_i,
	output logic doze_n_o,
	output logic power_down_req_o,
	output logic suspend_status_n_o,
	output logic standby_status_n_o,
	output logic mgmt_irq_req_n_o,
	output logic mgmt_irq_busy_o,
	output logic stop_grant_o,
	output logic [5:0] indicators_o,
	output logic thermal_active_o,
	output logic ring_wake_event_o,
	output logic suspend_tick_o,
	output logic [15:0] suspend_ticks_o,
	output logic [3:0] gpio_out_o,
	output logic [3:0] gpio_oe_o,
	output logic [6:0] prog_io_pins_out_o,
	output logic [6:0] prog_io_pins_oe_o,
	output logic [2:0] user_io_pins_out_o,
	output logic [2:0] user_io_pins_oe_o,
	output logic [13:0] io_rd_o
);
	localparam int SYNC_W = pmupi_pkg::IND_W + pmupi_pkg::IO_W + 3;
	// ack stages reset to the idle-high level, no false acknowledge
	localparam logic [SYNC_W-1:0] SYNC_RST = {3'b001, 20'h00000};
	logic [SYNC_W-1:0] async_in;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [pmupi_pkg::IND_W-1:0] ind_s;
	logic [pmupi_pkg::IO_W-1:0] io_s;
	logic ack_n_s;
	logic stpg_s;
	logic sclk_s;
	logic sclk_d_reg;
	logic ring_d_reg;
	logic [pmupi_pkg::IO_W-1:0] dir_reg;
	logic [pmupi_pkg::IO_W-1:0] dat_reg;
	logic [pmupi_pkg::SUSP_CNT_W-1:0] sticks_reg;
	logic tick_reg;
	logic wake_reg;
	logic doze_n_reg;
	logic pwrdn_reg;
	logic susp_n_reg;
	logic stby_n_reg;
	pmupi_pkg::pmupi_irq_e irq_reg;
	pmupi_pkg::pmupi_irq_e irq_next;

	// two stages on every pin input
	assign async_in = {suspend_clk_in_i, stop_grant_in_i, mgmt_irq_ack_n_i,
		user_io_pins_in_i, prog_io_pins_in_i, gpio_in_i,
		external_suspend_req_i, ring_wake_i, thermal_alarm_i,
		battery_very_low_i, battery_low_i, ac_power_present_i};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= SYNC_RST;
			sync2_reg <= SYNC_RST;
		end else if (ce_i) begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
		end
	end
	assign ind_s = sync2_reg[pmupi_pkg::IND_W-1:0];
	assign io_s = sync2_reg[pmupi_pkg::IND_W +: pmupi_pkg::IO_W];
	assign ack_n_s = sync2_reg[SYNC_W-3];
	assign stpg_s = sync2_reg[SYNC_W-2];
	assign sclk_s = sync2_reg[SYNC_W-1];

	// pin output levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			doze_n_reg <= pmupi_pkg::DOZE_RST;
			pwrdn_reg <= pmupi_pkg::PWRDN_RST;
			susp_n_reg <= pmupi_pkg::SUSP_N_RST;
			stby_n_reg <= pmupi_pkg::STBY_N_RST;
		end else if (ce_i) begin
			doze_n_reg <= ~doze_req_i;
			pwrdn_reg <= power_down_cmd_i;
			susp_n_reg <= ~suspend_mode_i;
			stby_n_reg <= ~standby_mode_i;
		end
	end

	// management interrupt handshake
	always_comb begin
		irq_next = irq_reg;
		unique case (irq_reg)
			pmupi_pkg::PMUPI_IRQ_IDLE: begin
				if (mgmt_irq_set_i) begin
					irq_next = pmupi_pkg::PMUPI_IRQ_REQ;
				end
			end
			pmupi_pkg::PMUPI_IRQ_REQ: begin
				if (!ack_n_s) begin
					irq_next = pmupi_pkg::PMUPI_IRQ_REL;
				end
			end
			pmupi_pkg::PMUPI_IRQ_REL: begin
				if (ack_n_s) begin
					irq_next = pmupi_pkg::PMUPI_IRQ_IDLE;
				end
			end
			default: begin
				irq_next = pmupi_pkg::PMUPI_IRQ_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= pmupi_pkg::PMUPI_IRQ_IDLE;
		end else if (ce_i) begin
			irq_reg <= irq_next;
		end
	end

	// io direction and data, per-bit write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_reg <= pmupi_pkg::IO_DIR_RST;
		end else if (ce_i) begin
			dir_reg <= (dir_reg & ~io_dir_we_i) | (io_dir_i & io_dir_we_i);
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= pmupi_pkg::IO_DAT_RST;
		end else if (ce_i) begin
			dat_reg <= (dat_reg & ~io_dat_we_i) | (io_dat_i & io_dat_we_i);
		end
	end

	// suspend timing from the slow oscillator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_d_reg <= 1'b0;
			tick_reg <= 1'b0;
			sticks_reg <= pmupi_pkg::SUSP_CNT_RST;
		end else if (ce_i) begin
			sclk_d_reg <= sclk_s;
			tick_reg <= sclk_s & ~sclk_d_reg;
			if (!suspend_mode_i) begin
				sticks_reg <= pmupi_pkg::SUSP_CNT_RST;
			end else if (tick_reg && sticks_reg != pmupi_pkg::SUSP_CNT_MAX) begin
				sticks_reg <= sticks_reg + 16'h0001;
			end
		end
	end

	// ring wake edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ring_d_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else if (ce_i) begin
			ring_d_reg <= ind_s[pmupi_pkg::IND_RING];
			wake_reg <= ind_s[pmupi_pkg::IND_RING] & ~ring_d_reg;
		end
	end

	assign doze_n_o = doze_n_reg;
	assign power_down_req_o = pwrdn_reg;
	assign suspend_status_n_o = susp_n_reg;
	assign standby_status_n_o = stby_n_reg;
	assign mgmt_irq_req_n_o = (irq_reg != pmupi_pkg::PMUPI_IRQ_REQ);
	assign mgmt_irq_busy_o = (irq_reg != pmupi_pkg::PMUPI_IRQ_IDLE);
	assign stop_grant_o = stpg_s;
	assign indicators_o = ind_s;
	assign thermal_active_o = ind_s[pmupi_pkg::IND_THERM];
	assign ring_wake_event_o = wake_reg;
	assign suspend_tick_o = tick_reg;
	assign suspend_ticks_o = sticks_reg;
	assign io_rd_o = io_s;
	assign gpio_out_o = dat_reg[pmupi_pkg::GPIO_LSB +: pmupi_pkg::GPIO_W];
	assign gpio_oe_o = dir_reg[pmupi_pkg::GPIO_LSB +: pmupi_pkg::GPIO_W];
	assign prog_io_pins_out_o = dat_reg[pmupi_pkg::PIO_LSB +: pmupi_pkg::PIO_W];
	assign prog_io_pins_oe_o = dir_reg[pmupi_pkg::PIO_LSB +: pmupi_pkg::PIO_W];
	assign user_io_pins_out_o = dat_reg[pmupi_pkg::UIO_LSB +: pmupi_pkg::UIO_W];
	assign user_io_pins_oe_o = dir_reg[pmupi_pkg::UIO_LSB +: pmupi_pkg::UIO_W];

	a_doze_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i |=> (doze_n_o == !$past(doze_req_i)))
		else $error("doze output does not follow request");
	a_doze_reset: assert property (@(posedge clk_i)
		rst_i |=> doze_n_o && !power_down_req_o)
		else $error("doze or power-down wrong after reset");
	a_pwrdn_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
		(power_down_req_o && $past(ce_i)) |-> $past(power_down_cmd_i))
		else $error("power-down without command");
	a_susp_mode: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && suspend_mode_i) |=> !suspend_status_n_o)
		else $error("suspend status not asserted");
	a_stby_mode: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !standby_mode_i) |=> standby_status_n_o)
		else $error("standby status asserted outside standby");
	a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !mgmt_irq_busy_o && mgmt_irq_set_i) |=> !mgmt_irq_req_n_o)
		else $error("interrupt request not raised");
	a_irq_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !mgmt_irq_req_n_o && !ack_n_s) |=> mgmt_irq_req_n_o)
		else $error("interrupt request held after acknowledge");
	a_io_reset: assert property (@(posedge clk_i)
		rst_i |=> (gpio_oe_o == 4'h0) && (prog_io_pins_oe_o == 7'h00)
			&& (user_io_pins_oe_o == 3'h0))
		else $error("io pin not input after reset");
	a_uio_alone: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && io_dat_we_i[pmupi_pkg::UIO_LSB] == 1'b0)
			|=> $stable(user_io_pins_out_o[0]))
		else $error("user io bit changed without its write");
	a_thermal_lat: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i [*3]) |-> thermal_active_o == $past(thermal_alarm_i, 2))
		else $error("thermal indicator not two stages behind pin");
	a_ring_wake: assert property (@(posedge clk_i) disable iff (rst_i)
		(ring_wake_event_o && $past(ce_i)) |-> ring_d_reg && !$past(ring_d_reg))
		else $error("wake event without ring edge");
	a_susp_tick: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !suspend_mode_i) |=> suspend_ticks_o == 16'h0000)
		else $error("suspend counter runs outside suspend");
endmodule : pmupi_top
`default_nettype wire

/* File: tb/pmupi_cpu_model.sv */
// cpu side model answering the management interrupt request
`default_nettype none
module pmupi_cpu_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] delay_i,
	input wire logic req_n_i,
	output var logic ack_n_o
);
	logic [7:0] cnt_reg;
	// ack low after delay while request low, released with request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_n_o <= 1'b1;
			cnt_reg <= 8'h00;
		end else if (!req_n_i) begin
			if (cnt_reg == delay_i) ack_n_o <= 1'b0;
			else cnt_reg <= cnt_reg + 8'h01;
		end else begin
			ack_n_o <= 1'b1;
			cnt_reg <= 8'h00;
		end
	end
endmodule : pmupi_cpu_model
`default_nettype wire

/* File: tb/pmupi_top_tb_top.sv */
// testbench for the power management pin interface
`default_nettype none
module pmupi_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, ce, set, sclk, stg, ack_n;
	logic [3:0] lev, gin;
	logic [5:0] ind;
	logic [6:0] pin;
	logic [2:0] uin;
	logic [13:0] dwe, dv, twe, tv;
	logic [7:0] dly;
	logic doze_n, pd, susp_n, stby_n, req_n, busy, sg, therm, ring, tick;
	logic [5:0] ind_o;
	logic [15:0] ticks;
	logic [3:0] g_out, g_oe;
	logic [6:0] p_out, p_oe;
	logic [2:0] u_out, u_oe;
	logic [13:0] rd;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	pmupi_top dut (.clk_i(clk), .rst_i(rst), .ce_i(ce),
		.doze_req_i(lev[0]), .power_down_cmd_i(lev[1]),
		.suspend_mode_i(lev[2]), .standby_mode_i(lev[3]),
		.mgmt_irq_set_i(set), .mgmt_irq_ack_n_i(ack_n),
		.stop_grant_in_i(stg), .suspend_clk_in_i(sclk),
		.ac_power_present_i(ind[0]), .battery_low_i(ind[1]),
		.battery_very_low_i(ind[2]), .thermal_alarm_i(ind[3]),
		.ring_wake_i(ind[4]), .external_suspend_req_i(ind[5]),
		.io_dir_we_i(dwe), .io_dir_i(dv), .io_dat_we_i(twe), .io_dat_i(tv),
		.gpio_in_i(gin), .prog_io_pins_in_i(pin), .user_io_pins_in_i(uin),
		.doze_n_o(doze_n), .power_down_req_o(pd),
		.suspend_status_n_o(susp_n), .standby_status_n_o(stby_n),
		.mgmt_irq_req_n_o(req_n), .mgmt_irq_busy_o(busy),
		.stop_grant_o(sg), .indicators_o(ind_o), .thermal_active_o(therm),
		.ring_wake_event_o(ring), .suspend_tick_o(tick),
		.suspend_ticks_o(ticks), .gpio_out_o(g_out), .gpio_oe_o(g_oe),
		.prog_io_pins_out_o(p_out), .prog_io_pins_oe_o(p_oe),
		.user_io_pins_out_o(u_out), .user_io_pins_oe_o(u_oe), .io_rd_o(rd));
	pmupi_cpu_model cpu (.clk_i(clk), .rst_i(rst), .delay_i(dly),
		.req_n_i(req_n), .ack_n_o(ack_n));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic test_reset;
		check({12'h000, doze_n, pd, susp_n, stby_n}, 16'h000b);
		check({15'h0000, req_n}, 16'h0001);
		check({2'h0, u_oe, p_oe, g_oe}, 16'h0000);
		$display("test reset done");
	endtask : test_reset
	task automatic test_levels;
		for (int i = 0; i < 4; i++) begin
			lev = 4'h1 << i;
			step(1);
			check({12'h000, doze_n, pd, susp_n, stby_n},
				{12'h000, ~lev[0], lev[1], ~lev[2], ~lev[3]});
		end
		ce = 1'b0;
		lev = 4'h0;
		step(2);
		check({12'h000, doze_n, pd, susp_n, stby_n}, 16'h000a);
		ce = 1'b1;
		step(1);
		check({12'h000, doze_n, pd, susp_n, stby_n}, 16'h000b);
		$display("test levels done");
	endtask : test_levels
	task automatic test_irq(input logic [7:0] d);
		int n;
		dly = d;
		set = 1'b1;
		step(1);
		set = 1'b0;
		check({14'h0000, req_n, busy}, 16'h0001);
		set = 1'b1;
		step(1);
		set = 1'b0;
		n = 0;
		while (req_n !== 1'b1 && n < 60) begin
			step(1);
			n++;
		end
		check({15'h0000, ack_n}, 16'h0000);
		while (busy !== 1'b0 && n < 60) begin
			step(1);
			n++;
		end
		check(16'(n < 60), 16'h0001);
		step(3);
		check({14'h0000, req_n, busy}, 16'h0002);
		$display("test irq done");
	endtask : test_irq
	task automatic test_io;
		dwe = 14'h0800;
		dv = 14'h3fff;
		step(1);
		dwe = 14'h0000;
		check({2'h0, u_oe, p_oe, g_oe}, 16'h0800);
		twe = 14'h0011;
		tv = 14'h3fff;
		step(1);
		twe = 14'h0000;
		check({2'h0, u_out, p_out, g_out}, 16'h0011);
		gin = 4'ha;
		pin = 7'h55;
		uin = 3'h5;
		step(2);
		check({2'h0, rd}, 16'h2d5a);
		$display("test io done");
	endtask : test_io
	task automatic test_ind;
		for (int i = 0; i < 6; i++) begin
			ind = 6'h01 << i;
			stg = ind[4];
			step(2);
			check({10'h000, ind_o}, {10'h000, ind});
			check({14'h0000, therm, sg}, {14'h0000, ind[3], ind[4]});
			step(1);
			check({15'h0000, ring}, {15'h0000, ind[4]});
		end
		ind = 6'h00;
		stg = 1'b0;
		$display("test indicators done");
	endtask : test_ind
	task automatic test_tick;
		lev = 4'h4;
		step(2);
		for (int i = 0; i < 3; i++) begin
			sclk = 1'b1;
			step(3);
			check({15'h0000, tick}, 16'h0001);
			step(1);
			sclk = 1'b0;
			step(4);
		end
		check(ticks, 16'h0003);
		lev = 4'h0;
		step(3);
		check(ticks, 16'h0000);
		$display("test tick done");
	endtask : test_tick
	initial begin
		{rst, ce, set, sclk, stg, lev, gin, ind, pin, uin} = '0;
		{dwe, dv, twe, tv, dly} = '0;
		rst = 1'b1;
		ce = 1'b1;
		step(10);
		test_reset();
		rst = 1'b0;
		test_levels();
		test_irq(8'h00);
		test_irq(8'h0a);
		test_io();
		test_ind();
		test_tick();
		rst = 1'b1;
		step(2);
		test_reset();
		rst = 1'b0;
		test_irq(8'h03);
		print_verdict();
	end
endmodule : pmupi_top_tb_top
`default_nettype wire
